/* File: hw/pcacc_consts.vh */
// register offsets, field positions and reset values of the capture/compare block
`ifndef PCACC_CONSTS_VH
`define PCACC_CONSTS_VH
`define PCACC_OFF_CNT_LOW 12'h000
`define PCACC_OFF_CNT_HIGH 12'h004
`define PCACC_OFF_CONTROL 12'h008
`define PCACC_OFF_MODE0 12'h00c
`define PCACC_OFF_MODE1 12'h010
`define PCACC_OFF_VAL0_LOW 12'h014
`define PCACC_OFF_VAL0_HIGH 12'h018
`define PCACC_OFF_VAL1_LOW 12'h01c
`define PCACC_OFF_VAL1_HIGH 12'h020
`define PCACC_OFF_AUX0 12'h024
`define PCACC_OFF_AUX1 12'h028
`define PCACC_OFF_IRQ 12'h02c
`define PCACC_BIT_CMP 6
`define PCACC_BIT_RISE 5
`define PCACC_BIT_FALL 4
`define PCACC_BIT_HIT 3
`define PCACC_BIT_TOG 2
`define PCACC_BIT_DUTY 1
`define PCACC_BIT_IRQ 0
`define PCACC_BIT_RUN 6
`define PCACC_BIT_RELOAD 1
`define PCACC_BIT_ACTIVE 0
`define PCACC_RST_MODE 7'h00
`define PCACC_RST_BYTE 8'h00
`define PCACC_CNT_WRAP 8'hff
`endif

/* File: hw/pcacc_module.v */
// one capture/compare module driven by the shared counter
`timescale 1ns/10ps
`default_nettype none
`include "pcacc_consts.vh"
module pcacc_module (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // shared counter
    input wire [15:0] count,
    input wire count_step,
    input wire low_wrap,
    // configuration
    input wire [6:0] mode,
    // software writes
    input wire wr_low,
    input wire wr_high,
    input wire wr_aux,
    input wire [7:0] wdata,
    // pin sample
    input wire pin_in,
    // state
    output reg [15:0] value_reg,
    output reg [1:0] aux_reg,
    output reg pin_out_reg,
    output reg event_set_reg
);
    wire cmp_en = mode[`PCACC_BIT_CMP];
    wire rise_en = mode[`PCACC_BIT_RISE];
    wire fall_en = mode[`PCACC_BIT_FALL];
    wire hit_en = mode[`PCACC_BIT_HIT];
    wire tog_en = mode[`PCACC_BIT_TOG];
    wire duty_en = mode[`PCACC_BIT_DUTY];
    wire irq_en = mode[`PCACC_BIT_IRQ];
    reg sync1_reg;
    reg sync2_reg;
    reg prev_reg;
    reg latch_reg;
    wire rise = sync2_reg & ~prev_reg;
    wire fall = ~sync2_reg & prev_reg;
    wire capture = (rise_en & rise) | (fall_en & fall);
    // match judged only once per counter value, so a halted counter
    // does not keep firing
    wire hit = cmp_en & count_step & (count == value_reg);
    wire duty_mode = duty_en & cmp_en & ~irq_en;
    wire [8:0] duty = {aux_reg[`PCACC_BIT_ACTIVE], value_reg[7:0]};
    wire duty_level = ({1'b0, count[7:0]} >= duty);
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
            value_reg <= 16'h0000;
            aux_reg <= 2'h0;
            // latch starts at the idle pin level, so enabling toggle
            // mode does not drop the pin before the first match
            latch_reg <= 1'b1;
            pin_out_reg <= 1'b1;
            event_set_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            event_set_reg <= capture | (hit & hit_en);
            if (capture) begin
                value_reg <= count;
            end else begin
                if (wr_low) begin
                    value_reg[7:0] <= wdata;
                end
                if (wr_high) begin
                    value_reg[15:8] <= wdata;
                end
            end
            if (wr_aux) begin
                aux_reg <= wdata[1:0];
            end else if (duty_mode && low_wrap) begin
                // active duty bit reloads from the reload bit on wrap
                aux_reg[`PCACC_BIT_ACTIVE] <= aux_reg[`PCACC_BIT_RELOAD];
            end
            if (duty_mode && low_wrap && !capture && !wr_low) begin
                value_reg[7:0] <= value_reg[15:8];
            end
            if (hit && tog_en) begin
                latch_reg <= ~latch_reg;
            end
            if (duty_en) begin
                pin_out_reg <= duty_mode ? duty_level : 1'b1;
            end else if (tog_en) begin
                pin_out_reg <= latch_reg ^ (hit & tog_en);
            end else begin
                pin_out_reg <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/pcacc_top.v */
// capture/compare array: shared counter, two modules and an APB slave
// Notes on behaviour
// - comparator enable, cleared at reset, turns on counter/value comparison
// - rising-capture enable latches counter on a rising pin edge
// - falling-capture enable latches on falling edge; both enables give both
// - hit-flag enable sets module event flag on counter match
// - invert-on-hit toggles the module pin on each match
// - duty-output enable routes the pulse-width output to the pin
// - interrupt request only while event flag and irq enable both set
// - capture copies both counter bytes and sets the event flag
// - software timer: comparator and hit-flag enable flag equality
// - high-speed output: pin latch inverts on every match
// - pulse-width mode needs duty and comparator enable, irq enable clear
// - all pulse-width outputs share the counter low byte period
// - pulse output low while low byte below 9-bit duty, else high
// - on low byte wrap FF to 00 the active duty reloads
// - aux register: bit 1 reload extra bit, bit 0 active extra bit
// - event flags set only by hardware, cleared only by software
// - counter runs only with run bit; module 0 and 1 on own pins
`timescale 1ns/10ps
`default_nettype none
`include "pcacc_consts.vh"
module pcacc_top #(
    parameter NMOD = 2
) (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // counter tick from the surrounding clock-source selection
    input wire count_tick,
    // module pins
    input wire [NMOD-1:0] module_pin_in,
    output reg [NMOD-1:0] module_pin_out,
    output reg [NMOD-1:0] module_pin_oe,
    // interrupt requests towards the system
    output reg [NMOD-1:0] module_irq
);
    reg [15:0] count_reg;
    reg counter_run_reg;
    reg [NMOD-1:0] event_flag_reg;
    reg [6:0] mode_reg [0:NMOD-1];
    reg [31:0] rdata_next;
    reg hit_next;
    wire acc = psel & penable & ~pready;
    wire wr = acc & pwrite;
    wire count_step = counter_run_reg & count_tick;
    wire low_wrap = count_step & (count_reg[7:0] == `PCACC_CNT_WRAP);
    wire [16*NMOD-1:0] value_bus;
    wire [2*NMOD-1:0] aux_bus;
    wire [NMOD-1:0] pin_bus;
    wire [NMOD-1:0] event_set;
    wire [NMOD-1:0] irq_en_bus;
    wire [NMOD-1:0] pin_drive;

    genvar g;
    generate
        for (g = 0; g < NMOD; g = g + 1) begin : mods
            wire [31:0] lo_full = `PCACC_OFF_VAL0_LOW + g * 8;
            wire [31:0] hi_full = `PCACC_OFF_VAL0_HIGH + g * 8;
            wire [31:0] aux_full = `PCACC_OFF_AUX0 + g * 4;
            wire [31:0] mode_full = `PCACC_OFF_MODE0 + g * 4;
            wire [11:0] lo_addr = lo_full[11:0];
            wire [11:0] hi_addr = hi_full[11:0];
            wire [11:0] aux_addr = aux_full[11:0];
            wire [11:0] mode_addr = mode_full[11:0];
            assign irq_en_bus[g] = mode_reg[g][`PCACC_BIT_IRQ];
            assign pin_drive[g] = mode_reg[g][`PCACC_BIT_DUTY]
                | mode_reg[g][`PCACC_BIT_TOG];
            always @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    mode_reg[g] <= `PCACC_RST_MODE;
                end else if (wr && paddr == mode_addr) begin
                    mode_reg[g] <= pwdata[6:0];
                end
            end
            pcacc_module u_mod (
                .mclk(mclk),
                .rstn(rstn),
                .count(count_reg),
                .count_step(count_step),
                .low_wrap(low_wrap),
                .mode(mode_reg[g]),
                .wr_low(wr && paddr == lo_addr),
                .wr_high(wr && paddr == hi_addr),
                .wr_aux(wr && paddr == aux_addr),
                .wdata(pwdata[7:0]),
                .pin_in(module_pin_in[g]),
                .value_reg(value_bus[16*g +: 16]),
                .aux_reg(aux_bus[2*g +: 2]),
                .pin_out_reg(pin_bus[g]),
                .event_set_reg(event_set[g])
            );
        end
    endgenerate

    // counter and control
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= 16'h0000;
            counter_run_reg <= 1'b0;
            event_flag_reg <= {NMOD{1'b0}};
        end else begin
            if (wr && paddr == `PCACC_OFF_CNT_LOW) begin
                count_reg[7:0] <= pwdata[7:0];
            end else if (wr && paddr == `PCACC_OFF_CNT_HIGH) begin
                count_reg[15:8] <= pwdata[7:0];
            end else if (count_step) begin
                count_reg <= count_reg + 16'h0001;
            end
            if (wr && paddr == `PCACC_OFF_CONTROL) begin
                counter_run_reg <= pwdata[`PCACC_BIT_RUN];
                // software may only clear; a same-cycle set wins
                event_flag_reg <= (event_flag_reg & pwdata[NMOD-1:0])
                    | event_set;
            end else begin
                event_flag_reg <= event_flag_reg | event_set;
            end
        end
    end

    // read mux
    integer i;
    always @* begin
        rdata_next = 32'h00000000;
        hit_next = 1'b1;
        case (paddr)
            `PCACC_OFF_CNT_LOW: rdata_next[7:0] = count_reg[7:0];
            `PCACC_OFF_CNT_HIGH: rdata_next[7:0] = count_reg[15:8];
            `PCACC_OFF_CONTROL: begin
                rdata_next[`PCACC_BIT_RUN] = counter_run_reg;
                rdata_next[NMOD-1:0] = event_flag_reg;
            end
            `PCACC_OFF_IRQ: rdata_next[NMOD-1:0] = module_irq;
            default: hit_next = 1'b0;
        endcase
        for (i = 0; i < NMOD; i = i + 1) begin
            if (paddr == `PCACC_OFF_MODE0 + i * 4) begin
                rdata_next[6:0] = mode_reg[i];
                hit_next = 1'b1;
            end
            if (paddr == `PCACC_OFF_VAL0_LOW + i * 8) begin
                rdata_next[7:0] = value_bus[16*i +: 8];
                hit_next = 1'b1;
            end
            if (paddr == `PCACC_OFF_VAL0_HIGH + i * 8) begin
                rdata_next[7:0] = value_bus[16*i+8 +: 8];
                hit_next = 1'b1;
            end
            if (paddr == `PCACC_OFF_AUX0 + i * 4) begin
                rdata_next[1:0] = aux_bus[2*i +: 2];
                hit_next = 1'b1;
            end
        end
    end

    // apb answer one cycle into the access phase; outputs registered
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            module_pin_out <= {NMOD{1'b1}};
            module_pin_oe <= {NMOD{1'b0}};
            module_irq <= {NMOD{1'b0}};
        end else begin
            pready <= acc;
            pslverr <= acc & ~hit_next;
            prdata <= (acc && !pwrite) ? rdata_next : 32'h00000000;
            module_pin_out <= pin_bus;
            module_pin_oe <= pin_drive;
            module_irq <= event_flag_reg & irq_en_bus;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/pcacc_pin_model.sv */
// far-side pin driver with two-way level resolution
`timescale 1ns/10ps
`default_nettype none
module pcacc_pin_model (
    // level the outside world puts on the pins
    input wire logic [1:0] ext_level,
    // design drivers
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    // resolved level
    output logic [1:0] pin_in
);
    // the design wins where it drives, so a toggling pin reads back
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

/* File: testbench/pcacc_top_props.sv */
// assertion checker for the capture/compare array ports
`timescale 1ns/10ps
`default_nettype none
`include "pcacc_consts.vh"
module pcacc_top_props #(
    parameter NMOD = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // counter and pins
    input wire logic count_tick,
    input wire logic [NMOD-1:0] module_pin_in,
    input wire logic [NMOD-1:0] module_pin_out,
    input wire logic [NMOD-1:0] module_pin_oe,
    input wire logic [NMOD-1:0] module_irq
);
    // module 0 mode, snooped from bus writes at the access edge
    logic [6:0] m0;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            m0 <= 7'h00;
        else if (psel && penable && pwrite && !pready
                 && paddr == `PCACC_OFF_MODE0)
            m0 <= pwdata[6:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_ready_follows: assert property (psel && penable && !pready |=> pready)
        else $error("no answer to access");
    a_irq_gated: assert property (module_irq[0] |-> $past(m0[0]))
        else $error("irq without enable");
    a_oe_mode: assert property (module_pin_oe[0] == $past(m0[1] | m0[2]))
        else $error("pin enable off mode");
    a_cmp_quiet: assert property (!m0[6] [*3]
        |=> $stable(module_pin_out[0]))
        else $error("pin moved without comparator");
    a_tick_quiet: assert property ((!count_tick && !psel) [*3]
        |=> $stable(module_pin_out)) else $error("pin moved on idle counter");
    a_cap_rise: assert property ($rose(module_pin_in[0]) && m0[5]
        && m0[0] |-> ##[2:6] module_irq[0]) else $error("no rise capture");
    a_cap_fall: assert property ($fell(module_pin_in[0]) && m0[4]
        && m0[0] |-> ##[2:6] module_irq[0]) else $error("no fall capture");
endmodule
bind pcacc_top pcacc_top_props #(.NMOD(NMOD)) i_props (.mclk(mclk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_tick(count_tick),
    .module_pin_in(module_pin_in), .module_pin_out(module_pin_out),
    .module_pin_oe(module_pin_oe), .module_irq(module_irq));
`default_nettype wire

/* File: testbench/pcacc_top_test.sv */
// self-checking bench for the capture/compare array
`timescale 1ns/10ps
`default_nettype none
`include "pcacc_consts.vh"
module pcacc_top_test;
    logic mclk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, tick = 1'h0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r = 32'h00010a65;
    logic [1:0] ext = 2'h0, pin_in, pin_out, pin_oe, irq;
    logic [32:0] q[$];
    int fail_count = 0, checks = 0;
    always #5 mclk = ~mclk;
    pcacc_top i_pcacc_top (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_tick(tick), .module_pin_in(pin_in), .module_pin_out(pin_out),
        .module_pin_oe(pin_oe), .module_irq(irq));
    pcacc_pin_model i_pcacc_pin_model (.ext_level(ext), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input [32:0] got, input [32:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input [11:0] a, input w, input [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        // pready is read as it stood at the edge; release follows it
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            fail_count++;
            final_report();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        apb(a, 1'h1, d);
    endtask
    task automatic rd(input [11:0] a, input [32:0] e);
        q.push_back(e);
        apb(a, 1'h0, 32'h0);
    endtask
    task automatic pin(input [32:0] e);
        repeat (8) @(posedge mclk);
        check({32'h0, pin_out[0]}, e);
    endtask
    task automatic pulse(input int n);
        tick <= 1'h1;
        repeat (n) @(posedge mclk);
        tick <= 1'h0;
    endtask
    // read results are paired with the oldest expectation
    always @(posedge mclk) begin
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, q.pop_front());
    end
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'h1;
        rd(`PCACC_OFF_MODE0, 33'h0);
        rd(12'h030, 33'h100000000);
        wr(`PCACC_OFF_CNT_LOW, 32'h34);
        wr(`PCACC_OFF_CNT_HIGH, 32'h12);
        wr(`PCACC_OFF_MODE0, 32'h21);
        ext[0] <= 1'h1;
        pin(33'h1);
        rd(`PCACC_OFF_VAL0_LOW, 33'h34);
        rd(`PCACC_OFF_VAL0_HIGH, 33'h12);
        rd(`PCACC_OFF_CONTROL, 33'h1);
        rd(`PCACC_OFF_IRQ, 33'h1);
        wr(`PCACC_OFF_CONTROL, 32'h0);
        rd(`PCACC_OFF_IRQ, 33'h0);
        wr(`PCACC_OFF_CNT_LOW, 32'h56);
        wr(`PCACC_OFF_CNT_HIGH, 32'h78);
        wr(`PCACC_OFF_MODE0, 32'h11);
        ext[0] <= 1'h0;
        pin(33'h1);
        rd(`PCACC_OFF_VAL0_LOW, 33'h56);
        rd(`PCACC_OFF_VAL0_HIGH, 33'h78);
        wr(`PCACC_OFF_CNT_LOW, 32'h5);
        wr(`PCACC_OFF_CNT_HIGH, 32'h0);
        wr(`PCACC_OFF_VAL0_LOW, 32'h7);
        wr(`PCACC_OFF_VAL0_HIGH, 32'h0);
        wr(`PCACC_OFF_CONTROL, 32'h40);
        wr(`PCACC_OFF_MODE0, 32'h4c);
        pulse(3);
        pin(33'h0);
        rd(`PCACC_OFF_CONTROL, 33'h41);
        wr(`PCACC_OFF_CONTROL, 32'h40);
        wr(`PCACC_OFF_MODE0, 32'h44);
        wr(`PCACC_OFF_CNT_LOW, 32'h7);
        pulse(1);
        pin(33'h1);
        rd(`PCACC_OFF_CONTROL, 33'h40);
        wr(`PCACC_OFF_CONTROL, 32'h0);
        wr(`PCACC_OFF_MODE0, 32'h42);
        wr(`PCACC_OFF_VAL0_LOW, 32'h80);
        wr(`PCACC_OFF_AUX0, 32'h0);
        wr(`PCACC_OFF_CNT_LOW, 32'h10);
        pin(33'h0);
        wr(`PCACC_OFF_CNT_LOW, 32'h90);
        pin(33'h1);
        wr(`PCACC_OFF_AUX0, 32'h1);
        pin(33'h0);
        wr(`PCACC_OFF_VAL0_HIGH, 32'ha0);
        wr(`PCACC_OFF_AUX0, 32'h2);
        wr(`PCACC_OFF_CNT_LOW, 32'hff);
        pin(33'h1);
        wr(`PCACC_OFF_CONTROL, 32'h40);
        pulse(1);
        pin(33'h0);
        rd(`PCACC_OFF_VAL0_LOW, 33'ha0);
        rd(`PCACC_OFF_AUX0, 33'h3);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            wr(`PCACC_OFF_VAL1_LOW, r);
            rd(`PCACC_OFF_VAL1_LOW, {25'h0, r[7:0]});
        end
        final_report();
    end
endmodule
`default_nettype wire
